/* hw/occp_pkg.sv */
// Constants for the outbound configuration cycle port
package occp_pkg;
    localparam int unsigned DATA_W         = 32;
    localparam int unsigned FUNC_SWAP_BIT  = 21;
    localparam int unsigned CFG_REG_W      = 32;
    localparam logic [1:0]  FUNC_ZERO      = 2'h0;
    localparam logic [1:0]  FUNC_ONE       = 2'h1;
    localparam logic [1:0]  FUNC_NONE      = 2'h3;
    localparam logic [31:0] CFG_ADDR_RESET = 32'h0000_0000;
    localparam logic [31:0] CFG_REG_RESET  = 32'h0000_0000;
    localparam logic        HDR_MF_RESET   = 1'h1;

    typedef enum logic [2:0] {
        OCCP_IDLE,
        OCCP_PCI_REQ,
        OCCP_PCI_WAIT,
        OCCP_DONE_RD
    } occp_state_t;
endpackage

/* hw/occp_func_map.sv */
// Function number mapping of bridge and translation unit
`timescale 1ns/1ps
`default_nettype none
module occp_func_map (
    input  wire logic       bridge_mf,
    input  wire logic       xlat_mf,
    input  wire logic       swap,
    output logic [1:0]      bridge_func,
    output logic [1:0]      xlat_func,
    output logic            bridge_abort,
    output logic            xlat_abort
);
    always_comb begin
        bridge_func  = occp_pkg::FUNC_ZERO;
        xlat_func    = occp_pkg::FUNC_ONE;
        bridge_abort = 1'b0;
        xlat_abort   = 1'b0;
        if (bridge_mf && xlat_mf) begin
            if (swap) begin
                bridge_func = occp_pkg::FUNC_ONE;
                xlat_func   = occp_pkg::FUNC_ZERO;
            end
        end else if (!bridge_mf && !xlat_mf) begin
            if (swap) begin
                bridge_func  = occp_pkg::FUNC_NONE;
                bridge_abort = 1'b1;
                xlat_func    = occp_pkg::FUNC_ZERO;
            end else begin
                xlat_func    = occp_pkg::FUNC_NONE;
                xlat_abort   = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/occp_port.sv */
// Outbound configuration cycle port
`timescale 1ns/1ps
`default_nettype none
module occp_port #(
    parameter int unsigned DW = occp_pkg::DATA_W
) (
    input  wire logic          clock,
    input  wire logic          rst_n,
    // Internal bus slave side
    input  wire logic          ib_valid,
    input  wire logic          ib_write,
    input  wire logic          ib_sel_addr,
    input  wire logic          ib_sel_data,
    input  wire logic          ib_burst,
    input  wire logic [DW-1:0] ib_wdata,
    output logic               ib_ack,
    output logic               ib_retry,
    output logic               ib_disconnect,
    output logic               ib_master_abort,
    output logic               internal_wide_ack,
    output logic [DW-1:0]      ib_rdata,
    output logic               bus_interface_unit_hold,
    output logic               bus_interface_unit_go,
    // Private range claim
    input  wire logic [DW-1:0] ib_addr,
    input  wire logic [DW-1:0] priv_base,
    input  wire logic [DW-1:0] priv_limit,
    input  wire logic          priv_enable,
    output logic               priv_claim,
    // PCI master side
    output logic               pci_req,
    output logic               pci_cfg_write,
    output logic [DW-1:0]      pci_addr,
    output logic [DW-1:0]      pci_wdata,
    output logic               pci_single_phase,
    input  wire logic          pci_done,
    input  wire logic          pci_master_abort,
    input  wire logic [DW-1:0] pci_rdata,
    // Function numbering
    input  wire logic          cfg_reg_we,
    input  wire logic [occp_pkg::CFG_REG_W-1:0] cfg_reg_wdata,
    input  wire logic          bridge_header_type_reg_mf,
    input  wire logic          translation_header_type_reg_mf,
    input  wire logic          hdr_we,
    output logic               mode3_violation,
    output logic [1:0]         bridge_func,
    output logic [1:0]         xlat_func,
    output logic               bridge_abort,
    output logic               xlat_abort,
    input  wire logic          mode3
);
    // Only the 32-bit single-word path exists
    if (DW != 32) begin
        $error("occp_port supports only a 32-bit data path");
    end

    occp_pkg::occp_state_t state_r;
    logic [DW-1:0] outbound_txn_queue_r;
    logic          armed_r;
    logic [DW-1:0] outbound_write_queue_r;
    logic          is_write_r;
    logic [DW-1:0] outbound_read_queue_r;
    logic          abort_r;
    logic          translation_unit_config_reg_r;
    logic          br_mf_r;
    logic          xl_mf_r;
    logic          busy;
    logic          occupied;
    logic          data_acc;
    logic          addr_acc;
    logic          complete_rd;

    assign busy        = (state_r != occp_pkg::OCCP_IDLE) && (state_r != occp_pkg::OCCP_DONE_RD);
    assign occupied    = (state_r != occp_pkg::OCCP_IDLE);
    assign data_acc    = ib_valid && ib_sel_data;
    assign addr_acc    = ib_valid && ib_sel_addr && ib_write;
    assign complete_rd = data_acc && !ib_write && (state_r == occp_pkg::OCCP_DONE_RD);

    // Internal bus answers
    always_comb begin
        ib_ack          = 1'b0;
        ib_retry        = 1'b0;
        ib_disconnect   = 1'b0;
        ib_master_abort = 1'b0;
        if (ib_valid && (ib_sel_addr || ib_sel_data)) begin
            // A pending read admits nothing but its own completion
            if (occupied && !complete_rd) begin
                ib_retry = 1'b1;
            end else if (data_acc && !ib_write && armed_r && !complete_rd) begin
                ib_retry = 1'b1;
            end else begin
                ib_ack          = !(complete_rd && abort_r);
                ib_master_abort = complete_rd && abort_r;
                ib_disconnect   = data_acc || ib_burst;
            end
        end
    end
    assign internal_wide_ack = 1'b0;
    assign ib_rdata          = outbound_read_queue_r;
    assign priv_claim = priv_enable && ib_valid && (ib_addr >= priv_base)
                        && (ib_addr <= priv_limit);

    // Stored address changes only on an address write
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outbound_txn_queue_r <= occp_pkg::CFG_ADDR_RESET;
            armed_r              <= 1'b0;
        end else if (addr_acc && !occupied) begin
            outbound_txn_queue_r <= ib_wdata;
            armed_r              <= 1'b1;
        end
    end

    // Transaction sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r                <= occp_pkg::OCCP_IDLE;
            outbound_write_queue_r <= '0;
            outbound_read_queue_r  <= '0;
            is_write_r             <= 1'b0;
            abort_r                <= 1'b0;
        end else begin
            case (state_r)
                occp_pkg::OCCP_IDLE: begin
                    if (data_acc && armed_r) begin
                        is_write_r <= ib_write;
                        if (ib_write) begin
                            outbound_write_queue_r <= ib_wdata;
                        end
                        state_r <= occp_pkg::OCCP_PCI_REQ;
                    end
                end
                occp_pkg::OCCP_PCI_REQ: begin
                    state_r <= occp_pkg::OCCP_PCI_WAIT;
                end
                occp_pkg::OCCP_PCI_WAIT: begin
                    if (pci_done) begin
                        abort_r <= pci_master_abort;
                        if (!is_write_r) begin
                            outbound_read_queue_r <= pci_rdata;
                            state_r <= occp_pkg::OCCP_DONE_RD;
                        end else begin
                            state_r <= occp_pkg::OCCP_IDLE;
                        end
                    end
                end
                occp_pkg::OCCP_DONE_RD: begin
                    if (complete_rd) begin
                        state_r <= occp_pkg::OCCP_IDLE;
                    end
                end
                default: state_r <= occp_pkg::OCCP_IDLE;
            endcase
        end
    end

    assign pci_req          = (state_r == occp_pkg::OCCP_PCI_REQ)
                              || (state_r == occp_pkg::OCCP_PCI_WAIT);
    assign pci_cfg_write    = is_write_r;
    assign pci_addr         = outbound_txn_queue_r;
    assign pci_wdata        = outbound_write_queue_r;
    assign pci_single_phase = 1'b1;
    assign bus_interface_unit_hold = busy;
    assign bus_interface_unit_go   = (state_r == occp_pkg::OCCP_DONE_RD);

    // Function numbering settings
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            translation_unit_config_reg_r <= occp_pkg::CFG_REG_RESET[occp_pkg::FUNC_SWAP_BIT];
        end else if (cfg_reg_we) begin
            translation_unit_config_reg_r <= cfg_reg_wdata[occp_pkg::FUNC_SWAP_BIT];
        end
    end
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            br_mf_r <= occp_pkg::HDR_MF_RESET;
            xl_mf_r <= occp_pkg::HDR_MF_RESET;
        end else if (hdr_we) begin
            br_mf_r <= bridge_header_type_reg_mf;
            xl_mf_r <= translation_header_type_reg_mf;
        end
    end
    assign mode3_violation = (cfg_reg_we || hdr_we) && !mode3;

    occp_func_map u_map (
        .bridge_mf    (br_mf_r),
        .xlat_mf      (xl_mf_r),
        .swap         (translation_unit_config_reg_r),
        .bridge_func  (bridge_func),
        .xlat_func    (xlat_func),
        .bridge_abort (bridge_abort),
        .xlat_abort   (xlat_abort)
    );

    // Checks
    busy_retry_a: assert property (@(posedge clock) disable iff (!rst_n)
        (busy && ib_valid && ib_sel_data) |-> ib_retry)
        else $error("access not retried while busy");
    no_wide_a: assert property (@(posedge clock) disable iff (!rst_n)
        !internal_wide_ack)
        else $error("wide ack asserted");
    read_retry_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == occp_pkg::OCCP_IDLE && data_acc && !ib_write && armed_r)
        |-> ib_retry ##1 (state_r == occp_pkg::OCCP_PCI_REQ))
        else $error("read did not start delayed cycle");
    addr_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        !addr_acc |=> $stable(pci_addr))
        else $error("address changed without write");
    write_disc_a: assert property (@(posedge clock) disable iff (!rst_n)
        (data_acc && ib_write && !occupied) |-> (ib_disconnect && ib_ack))
        else $error("write not disconnected");
    abort_back_a: assert property (@(posedge clock) disable iff (!rst_n)
        (complete_rd && abort_r) |-> ib_master_abort)
        else $error("master abort lost");
    biu_go_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == occp_pkg::OCCP_PCI_WAIT && pci_done && !is_write_r) |=> bus_interface_unit_go)
        else $error("bus unit not notified");
    swap_map_a: assert property (@(posedge clock) disable iff (!rst_n)
        (br_mf_r && xl_mf_r && translation_unit_config_reg_r) |-> (xlat_func == 2'h0))
        else $error("swap not applied");

    // Launch, queues, completion and private range claim
    pend_retry_a: assert property (@(posedge clock) disable iff (!rst_n)
        (bus_interface_unit_go && ib_valid && ib_write && (ib_sel_addr || ib_sel_data))
        |-> ib_retry)
        else $error("access not retried while read pending");
    no_double_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(ib_ack && ib_retry))
        else $error("ack and retry together");
    flight_one_a: assert property (@(posedge clock) disable iff (!rst_n)
        (pci_req && ib_valid && (ib_sel_addr || ib_sel_data)) |-> !ib_ack)
        else $error("access taken while transaction in flight");
    arm_only_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!occupied && addr_acc && !ib_sel_data) |=> !pci_req)
        else $error("address write started a cycle");
    rd_launch_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!occupied && data_acc && !ib_write && armed_r) |=> (pci_req && !pci_cfg_write))
        else $error("read not launched");
    wr_launch_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!occupied && data_acc && ib_write && armed_r)
        |=> (pci_req && pci_cfg_write && (pci_wdata == $past(ib_wdata))))
        else $error("write not launched with its data");
    one_phase_a: assert property (@(posedge clock) disable iff (!rst_n)
        pci_req |-> pci_single_phase)
        else $error("burst requested on PCI");
    req_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (pci_req && !pci_done) |=> pci_req)
        else $error("request dropped before completion");
    burst_cut_a: assert property (@(posedge clock) disable iff (!rst_n)
        (data_acc && ib_burst && ib_ack) |-> ib_disconnect)
        else $error("burst not disconnected");
    abort_no_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
        ib_master_abort |-> !ib_ack)
        else $error("abort and ack together");
    wr_narrow_a: assert property (@(posedge clock) disable iff (!rst_n)
        (data_acc && ib_write && ib_ack) |-> (ib_disconnect && !internal_wide_ack))
        else $error("data write not ended as 32-bit");
    rq_fill_a: assert property (@(posedge clock) disable iff (!rst_n)
        (state_r == occp_pkg::OCCP_PCI_WAIT && pci_done && !is_write_r)
        |=> (ib_rdata == $past(pci_rdata)))
        else $error("read data not queued");
    no_store_a: assert property (@(posedge clock) disable iff (!rst_n)
        (data_acc && ib_write && !occupied) |=> (ib_rdata == $past(ib_rdata)))
        else $error("write data became readable");
    go_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
        (bus_interface_unit_go && !complete_rd) |=> bus_interface_unit_go)
        else $error("notice dropped before completion");
    go_excl_a: assert property (@(posedge clock) disable iff (!rst_n)
        !(bus_interface_unit_go && bus_interface_unit_hold))
        else $error("hold and go together");
    claim_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
        !priv_enable |-> !priv_claim)
        else $error("claim while disabled");
    // Function numbering
    default_map_a: assert property (@(posedge clock) disable iff (!rst_n)
        (br_mf_r && xl_mf_r && !translation_unit_config_reg_r)
        |-> (bridge_func == occp_pkg::FUNC_ZERO && xlat_func == occp_pkg::FUNC_ONE))
        else $error("default numbering wrong");
    swap_bridge_a: assert property (@(posedge clock) disable iff (!rst_n)
        (br_mf_r && xl_mf_r && translation_unit_config_reg_r) |-> (bridge_func == 2'h1))
        else $error("bridge not moved to function one");
    single_fn_a: assert property (@(posedge clock) disable iff (!rst_n)
        (!br_mf_r && !xl_mf_r) |-> (bridge_abort != xlat_abort))
        else $error("single function mode wrong");
    bridge_off_a: assert property (@(posedge clock) disable iff (!rst_n)
        bridge_abort
        |-> (bridge_func == occp_pkg::FUNC_NONE && xlat_func == occp_pkg::FUNC_ZERO))
        else $error("disabled bridge numbering wrong");
endmodule
`default_nettype wire

/* verif/occp_pci_target.sv */
// Behavioural configuration target on the PCI side of the port
`timescale 1ns/1ps
`default_nettype none
module occp_pci_target (
    input  wire logic        clock,
    input  wire logic        pci_req,
    input  wire logic        pci_single_phase,
    input  wire logic [31:0] pci_addr,
    input  wire logic        abort_mode,
    output logic             pci_done,
    output logic             pci_master_abort,
    output logic [31:0]      pci_rdata
);
    int          wait_cnt = 0;
    logic        served   = 1'h0;
    logic [31:0] noise    = 32'h0;
    initial begin
        pci_done = 1'h0;
        pci_master_abort = 1'h0;
        pci_rdata = 32'h0;
    end
    // Answer lines churn outside the single done cycle
    always @(negedge clock) begin
        noise <= noise + 32'h1;
        pci_done <= 1'h0;
        pci_master_abort <= noise[0];
        pci_rdata <= ~noise;
        if (pci_req !== 1'h1) begin
            served <= 1'h0;
            wait_cnt <= 0;
        end else if (!served && pci_single_phase === 1'h1) begin
            if (wait_cnt == 5) begin
                pci_done <= 1'h1;
                pci_master_abort <= abort_mode;
                pci_rdata <= pci_addr ^ 32'h5a5a_a5a5;
                served <= 1'h1;
            end else begin
                wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

/* verif/occp_port_bench.sv */
// Self-checking bench for the outbound configuration cycle port
`timescale 1ns/1ps
`default_nettype none
module occp_port_bench;
    logic        clock = 1'h0, rst_n = 1'h0, v = 1'h0, wr = 1'h0, sa = 1'h0, sd = 1'h0;
    logic        bu = 1'h0, mfb = 1'h1, mfx = 1'h1, hwe = 1'h0, cwe = 1'h0, pen = 1'h0;
    logic        abm = 1'h0, ack, rty, dis, mab, wack, hold, go, claim, preq, pwr, pone;
    logic        pdone, pab, bab, xab, m3v, m3 = 1'h1;
    logic [31:0] wd = 32'h0, ad = 32'h0, cwd = 32'h0, rd, pa, pwd, prd, rdv;
    logic [1:0]  bf, xf;
    logic [4:0]  r;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    always #2.5 clock = ~clock;
    occp_port dut_u (.clock(clock), .rst_n(rst_n), .ib_valid(v), .ib_write(wr),
        .ib_sel_addr(sa), .ib_sel_data(sd), .ib_burst(bu), .ib_wdata(wd), .ib_ack(ack),
        .ib_retry(rty), .ib_disconnect(dis), .ib_master_abort(mab), .internal_wide_ack(wack),
        .ib_rdata(rd), .bus_interface_unit_hold(hold), .bus_interface_unit_go(go),
        .ib_addr(ad), .priv_base(32'h0001_0000), .priv_limit(32'h0001_ffff),
        .priv_enable(pen), .priv_claim(claim), .pci_req(preq), .pci_cfg_write(pwr),
        .pci_addr(pa), .pci_wdata(pwd), .pci_single_phase(pone), .pci_done(pdone),
        .pci_master_abort(pab), .pci_rdata(prd), .cfg_reg_we(cwe), .cfg_reg_wdata(cwd),
        .bridge_header_type_reg_mf(mfb), .translation_header_type_reg_mf(mfx),
        .hdr_we(hwe), .mode3_violation(m3v), .bridge_func(bf), .xlat_func(xf),
        .bridge_abort(bab), .xlat_abort(xab), .mode3(m3));
    occp_pci_target tgt_u (.clock(clock), .pci_req(preq), .pci_single_phase(pone),
        .pci_addr(pa), .abort_mode(abm), .pci_done(pdone), .pci_master_abort(pab),
        .pci_rdata(prd));
    task automatic conclude;
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    // One access held through its taking edge; answers sampled in its cycle
    task automatic acc(input logic w, a, d, b, input logic [31:0] x);
        @(negedge clock);
        {v, wr, sa, sd, bu, wd} = {1'h1, w, a, d, b, x};
        #1;
        r = {ack, rty, dis, mab, wack};
        rdv = rd;
        @(posedge clock);
        @(negedge clock);
        {v, sa, sd, bu} = 4'h0;
    endtask
    task automatic wait_for(input logic want_go);
        int i;
        for (i = 0; i < 40; i++) begin
            @(negedge clock);
            if ((want_go && go === 1'h1) || (!want_go && preq === 1'h0)) return;
        end
        n_mismatch++;
        conclude();
    endtask
    task automatic t_reset;
        chk("bridge_func", bf, 32'h0);
        chk("xlat_func", xf, 32'h1);
        chk("aborts", {bab, xab}, 32'h0);
        chk("pci_req idle", preq, 32'h0);
    endtask
    task automatic t_write;
        acc(1'h1, 1'h1, 1'h0, 1'h0, 32'h8000_0a10);
        @(negedge clock);
        chk("addr write arms only", preq, 32'h0);
        acc(1'h1, 1'h0, 1'h1, 1'h1, 32'hcafe_0123);
        chk("burst write answer", r, 32'h14);
        chk("write launch", {preq, pwr, pone, hold}, 32'hf);
        chk("write addr", pa, 32'h8000_0a10);
        chk("write data", pwd, 32'hcafe_0123);
        acc(1'h1, 1'h1, 1'h0, 1'h0, 32'h8000_0b20);
        chk("busy retry", r[3], 32'h1);
        wait_for(1'h0);
    endtask
    task automatic t_read(input logic ab);
        abm = ab;
        acc(1'h0, 1'h0, 1'h1, 1'h0, 32'h0);
        chk("read retried", r[4:3], 32'h1);
        chk("read launch", {preq, pwr}, 32'h2);
        chk("kept addr", pa, 32'h8000_0a10);
        wait_for(1'h1);
        chk("go", go, 32'h1);
        acc(1'h1, 1'h0, 1'h1, 1'h0, 32'h1111_2222);
        chk("pending retry", r, 32'h8);
        acc(1'h0, 1'h0, 1'h1, 1'h0, 32'h0);
        chk("completion abort", {r[4], r[1]}, {30'h0, !ab, ab});
        if (!ab) chk("read data", rdv, 32'hda5a_afb5);
        abm = 1'h0;
        wait_for(1'h0);
    endtask
    task automatic t_func;
        logic [2:0] row [5] = '{3'h6, 3'h7, 3'h0, 3'h1, 3'h5};
        logic [5:0] exp [5] = '{6'h04, 6'h10, 6'h0d, 6'h32, 6'h04};
        int i;
        for (i = 0; i < 5; i++) begin
            @(negedge clock);
            {mfb, mfx, cwd[21]} = row[i];
            {hwe, cwe} = 2'h3;
            #1;
            chk("mode3 quiet", m3v, 32'h0);
            @(negedge clock);
            {hwe, cwe} = 2'h0;
            @(negedge clock);
            chk("func map", {bf, xf, bab, xab}, {26'h0, exp[i]});
        end
        @(negedge clock);
        {m3, cwe} = 2'h1;
        #1;
        chk("mode3 flag", m3v, 32'h1);
        @(negedge clock);
        {m3, cwe} = 2'h2;
    endtask
    task automatic t_priv;
        pen = 1'h1;
        @(negedge clock);
        {v, ad} = {1'h1, 32'h0001_0400};
        #1;
        chk("claim inside", claim, 32'h1);
        @(negedge clock);
        ad = 32'h0003_0000;
        #1;
        chk("claim outside", claim, 32'h0);
        @(negedge clock);
        ad = 32'h0001_ffff;
        #1;
        chk("claim limit", claim, 32'h1);
        @(negedge clock);
        ad = 32'h0000_ffff;
        #1;
        chk("claim below", claim, 32'h0);
        @(negedge clock);
        v = 1'h0;
    endtask
    initial begin
        repeat (3) @(negedge clock);
        rst_n = 1'h1;
        @(negedge clock);
        t_reset();
        t_write();
        t_read(1'h0);
        t_read(1'h1);
        t_func();
        t_priv();
        conclude();
    end
endmodule
`default_nettype wire
